// ### core/ext_cfg_consts.vh
`ifndef EXT_CFG_CONSTS_VH
`define EXT_CFG_CONSTS_VH
// APB register byte offsets.
`define REG_CMD_ADDR 12'h000
`define REG_CMD_CTRL 12'h004
`define REG_STATUS 12'h008
`define REG_EXT_ONE 12'h00C
`define REG_EXT_TWO 12'h010
`define REG_EXT_THREE 12'h014
`define REG_IMPEDANCE 12'h018
`define REG_CAL_CODE 12'h01C
// Command control bit positions.
`define CTRL_CS_N 0
`define CTRL_RAS_N 1
`define CTRL_CAS_N 2
`define CTRL_WE_N 3
`define CTRL_BA_LSB 4
`define CTRL_CKE 7
`define CTRL_SELF_REF 8
`define CTRL_READ 9
`define CTRL_WRITE 10
`define CTRL_X8 11
// Extended register one fields.
`define F_DLL_DIS 0
`define F_HALF_DRV 1
`define F_TERM_LO 2
`define F_AL_LSB 3
`define F_TERM_HI 6
`define F_CAL_LSB 7
`define F_SE_STROBE 10
`define F_XSTROBE_EN 11
`define F_OUT_OFF 12
// Bank select codes.
`define BA_EXT_ONE 3'h1
`define BA_EXT_TWO 3'h2
`define BA_EXT_THREE 3'h3
// Calibration operations.
`define CAL_EXIT 3'h0
`define CAL_DRIVE1 3'h1
`define CAL_DRIVE0 3'h2
`define CAL_ADJUST 3'h4
`define CAL_DEFAULT 3'h7
// Impedance range and default step.
`define IMP_MAX 4'hF
`define IMP_DEFAULT 4'h8
// Drive settle time in ns and cycles at 5 ns.
`define DRIVE_SETTLE_NS 10
`define CLK_PERIOD_NS 5
`define DRIVE_SETTLE_CYC ((`DRIVE_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DLL_LOCK_CYC 200
`endif

// ### core/imp_step.v
`timescale 1ns/100ps
`default_nettype none
// Saturating 16-step impedance counter for one driver leg.
module imp_step (
	input wire clk_i,
	input wire rst_n_i,
	input wire load_i,
	input wire inc_i,
	input wire dec_i,
	output reg [3:0] step_o
);
`include "ext_cfg_consts.vh"
	// Steps stop at the ends so a runaway controller cannot wrap.
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			step_o <= `IMP_DEFAULT;
		end else if (load_i) begin
			step_o <= `IMP_DEFAULT;
		end else if (inc_i && step_o != `IMP_MAX) begin
			step_o <= step_o + 4'h1;
		end else if (dec_i && step_o != 4'h0) begin
			step_o <= step_o - 4'h1;
		end
	end
endmodule
`default_nettype wire

// ### core/settle_timer.v
`timescale 1ns/100ps
`default_nettype none
// Delays a level change by a fixed number of cycles.
module settle_timer (
	input wire clk_i,
	input wire rst_n_i,
	input wire req_i,
	output reg done_o
);
`include "ext_cfg_consts.vh"
	reg [3:0] cnt;
	// Output follows request only after it stays steady for the settle time.
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= 4'h0;
			done_o <= 1'b0;
		end else if (req_i == done_o) begin
			cnt <= 4'h0;
		end else if (cnt == `DRIVE_SETTLE_CYC - 1) begin
			cnt <= 4'h0;
			done_o <= req_i;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule
`default_nettype wire

// ### core/ext_cfg_block.v
// The register addresses and the APB register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module ext_cfg_block (
	input wire CLK_I,
	input wire RST_N_I,
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire PWRITE_I,
	input wire [11:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	output reg [31:0] PRDATA_O,
	output wire PREADY_O,
	output wire PSLVERR_O,
	output reg DLL_EN_O,
	output reg DLL_RESET_O,
	output reg HALF_DRIVE_O,
	output reg [1:0] TERM_SEL_O,
	output reg [2:0] ADDED_LATENCY_O,
	output reg [3:0] PULLUP_STEP_O,
	output reg [3:0] PULLDN_STEP_O,
	output reg DQ_O,
	output reg DQ_OE_N_O,
	output reg DQS_O,
	output reg DQS_OE_N_O,
	output reg DQS_B_O,
	output reg DQS_B_OE_N_O,
	output reg XSTROBE_O,
	output reg XSTROBE_OE_N_O,
	output reg XSTROBE_B_O,
	output reg XSTROBE_B_OE_N_O,
	output reg DATA_MASK_EN_O
);
`include "ext_cfg_consts.vh"
	// Calibration states.
	localparam ST_IDLE = 4'b0001;
	localparam ST_DRIVE = 4'b0010;
	localparam ST_ADJ = 4'b0100;
	localparam ST_BEATS = 4'b1000;

	reg [15:0] cmd_addr;
	reg [11:0] cmd_ctrl;
	reg [15:0] ext_one;
	reg [15:0] ext_two;
	reg [15:0] ext_three;
	reg [3:0] cal_code;
	reg cmd_go;
	reg [3:0] state;
	reg [3:0] next_state;
	reg drive_level;
	reg [1:0] beat_cnt;
	reg [3:0] beats;
	reg [7:0] lock_cnt;
	reg self_ref_d;
	reg strobe_phase;
	wire wr_en;
	wire rd_en;
	wire cfg_cmd;
	wire [2:0] bank;
	wire [2:0] cal_op;
	wire drive_req;
	wire drive_on;
	wire up_inc;
	wire up_dec;
	wire dn_inc;
	wire dn_dec;
	wire cal_load;
	wire beat_done;
	wire [3:0] step_req;
	wire outputs_off;
	wire reading;
	wire x8_strobe;
	wire [3:0] pu_step;
	wire [3:0] pd_step;

	// Decodes a full 4-beat code into the four step requests.
	function [3:0] decode_code;
		input [3:0] code;
		begin
			case (code)
				4'h1: decode_code = 4'b0001;
				4'h2: decode_code = 4'b0010;
				4'h4: decode_code = 4'b0100;
				4'h8: decode_code = 4'b1000;
				4'h5: decode_code = 4'b0101;
				4'h6: decode_code = 4'b0110;
				4'h9: decode_code = 4'b1001;
				4'hA: decode_code = 4'b1010;
				default: decode_code = 4'b0000;
			endcase
		end
	endfunction

	// APB answers with no wait state; unmapped reads give zero.
	assign PREADY_O = 1'b1;
	assign PSLVERR_O = 1'b0;
	assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;
	assign rd_en = PSEL_I && !PENABLE_I && !PWRITE_I;

	// Software registers; a write to control issues one command.
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cmd_addr <= 16'h0000;
			cmd_ctrl <= 12'h00F;
			cmd_go <= 1'b0;
		end else begin
			cmd_go <= 1'b0;
			if (wr_en && PADDR_I == `REG_CMD_ADDR) begin
				cmd_addr <= PWDATA_I[15:0];
			end
			if (wr_en && PADDR_I == `REG_CMD_CTRL) begin
				cmd_ctrl <= PWDATA_I[11:0];
				cmd_go <= 1'b1;
			end
		end
	end

	// Read data is captured in setup so it is stable in access phase.
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			PRDATA_O <= 32'h00000000;
		end else if (rd_en) begin
			case (PADDR_I)
				`REG_CMD_ADDR: PRDATA_O <= {16'h0000, cmd_addr};
				`REG_CMD_CTRL: PRDATA_O <= {20'h00000, cmd_ctrl};
				`REG_STATUS: PRDATA_O <= {20'h00000, lock_cnt, state};
				`REG_EXT_ONE: PRDATA_O <= {16'h0000, ext_one};
				`REG_EXT_TWO: PRDATA_O <= {16'h0000, ext_two};
				`REG_EXT_THREE: PRDATA_O <= {16'h0000, ext_three};
				`REG_IMPEDANCE: PRDATA_O <= {24'h000000, pd_step, pu_step};
				`REG_CAL_CODE: PRDATA_O <= {28'h0000000, cal_code};
				default: PRDATA_O <= 32'h00000000;
			endcase
		end
	end

	assign cfg_cmd = cmd_go && !cmd_ctrl[`CTRL_CS_N] && !cmd_ctrl[`CTRL_RAS_N]
		&& !cmd_ctrl[`CTRL_CAS_N] && !cmd_ctrl[`CTRL_WE_N];
	assign bank = cmd_ctrl[`CTRL_BA_LSB+2:`CTRL_BA_LSB];
	assign cal_op = ext_one[`F_CAL_LSB+2:`F_CAL_LSB];

	// Extended registers; reset clears them to zero until first written.
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ext_one <= 16'h0000;
			ext_two <= 16'h0000;
			ext_three <= 16'h0000;
		end else if (cfg_cmd) begin
			if (bank == `BA_EXT_ONE) begin
				ext_one <= cmd_addr;
			end
			if (bank == `BA_EXT_TWO && cmd_ctrl[`CTRL_CKE]) begin
				ext_two <= cmd_addr;
			end
			if (bank == `BA_EXT_THREE) begin
				ext_three <= cmd_addr;
			end
		end
	end

	// Field outputs follow the stored register one bits.
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			DLL_EN_O <= 1'b0;
			HALF_DRIVE_O <= 1'b0;
			TERM_SEL_O <= 2'h0;
			ADDED_LATENCY_O <= 3'h0;
			DATA_MASK_EN_O <= 1'b1;
		end else begin
			// loop enable bit, self-refresh forces off
			DLL_EN_O <= !ext_one[`F_DLL_DIS] && !cmd_ctrl[`CTRL_SELF_REF];
			HALF_DRIVE_O <= ext_one[`F_HALF_DRV];
			TERM_SEL_O <= {ext_one[`F_TERM_HI], ext_one[`F_TERM_LO]};
			ADDED_LATENCY_O <= ext_one[`F_AL_LSB+2:`F_AL_LSB];
			DATA_MASK_EN_O <= !(cmd_ctrl[`CTRL_X8] && ext_one[`F_XSTROBE_EN]);
		end
	end

	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			self_ref_d <= 1'b0;
			DLL_RESET_O <= 1'b0;
			lock_cnt <= 8'h00;
		end else begin
			self_ref_d <= cmd_ctrl[`CTRL_SELF_REF];
			DLL_RESET_O <= self_ref_d && !cmd_ctrl[`CTRL_SELF_REF];
			// Lock count is status only; the controller owns the 200-cycle wait.
			if (DLL_RESET_O) begin
				lock_cnt <= 8'h00;
			end else if (lock_cnt != `DLL_LOCK_CYC) begin
				lock_cnt <= lock_cnt + 8'h01;
			end
		end
	end

	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (cal_op == `CAL_DRIVE1 || cal_op == `CAL_DRIVE0) begin
					next_state = ST_DRIVE;
				end else if (cal_op == `CAL_ADJUST) begin
					next_state = ST_ADJ;
				end
			end
			ST_DRIVE: begin
				if (cal_op == `CAL_EXIT) begin
					next_state = ST_IDLE;
				end
			end
			ST_ADJ: begin
				if (cal_op == `CAL_EXIT) begin
					next_state = ST_IDLE;
				end else if (cmd_go && cmd_ctrl[`CTRL_WRITE]) begin
					next_state = ST_BEATS;
				end
			end
			ST_BEATS: begin
				if (beat_cnt == 2'h3) begin
					next_state = ST_ADJ;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// Beat n comes from bit n of the staged command word, as the bus is too slow per beat.
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state <= ST_IDLE;
			beat_cnt <= 2'h0;
			beats <= 4'h0;
			cal_code <= 4'h0;
			drive_level <= 1'b0;
		end else begin
			state <= next_state;
			if (state == ST_IDLE) begin
				drive_level <= (cal_op == `CAL_DRIVE1);
			end
			if (state == ST_BEATS) begin
				beat_cnt <= beat_cnt + 2'h1;
				beats <= {beats[2:0], cmd_addr[beat_cnt]};
				if (beat_cnt == 2'h3) begin
					cal_code <= {beats[2:0], cmd_addr[beat_cnt]};
				end
			end else begin
				beat_cnt <= 2'h0;
			end
		end
	end

	assign beat_done = (state == ST_BEATS) && (beat_cnt == 2'h3);
	assign step_req = decode_code({beats[2:0], cmd_addr[3]});
	assign up_inc = beat_done && step_req[0];
	assign up_dec = beat_done && step_req[1];
	assign dn_inc = beat_done && step_req[2];
	assign dn_dec = beat_done && step_req[3];
	assign cal_load = cfg_cmd && bank == `BA_EXT_ONE
		&& cmd_addr[`F_CAL_LSB+2:`F_CAL_LSB] == `CAL_DEFAULT;

	// One shared setting covers every DQ driver.
	imp_step u_pullup (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.load_i(cal_load),
		.inc_i(up_inc),
		.dec_i(up_dec),
		.step_o(pu_step)
	);

	imp_step u_pulldn (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.load_i(cal_load),
		.inc_i(dn_inc),
		.dec_i(dn_dec),
		.step_o(pd_step)
	);

	assign drive_req = (state == ST_DRIVE);
	settle_timer u_settle (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.req_i(drive_req),
		.done_o(drive_on)
	);

	assign outputs_off = ext_one[`F_OUT_OFF];
	assign reading = cmd_ctrl[`CTRL_READ] && !cmd_ctrl[`CTRL_WRITE];
	assign x8_strobe = cmd_ctrl[`CTRL_X8] && ext_one[`F_XSTROBE_EN];

	// Pin drive; output enables are active low.
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			strobe_phase <= 1'b0;
			PULLUP_STEP_O <= `IMP_DEFAULT;
			PULLDN_STEP_O <= `IMP_DEFAULT;
			DQ_O <= 1'b0;
			DQ_OE_N_O <= 1'b1;
			DQS_O <= 1'b0;
			DQS_OE_N_O <= 1'b1;
			DQS_B_O <= 1'b1;
			DQS_B_OE_N_O <= 1'b1;
			XSTROBE_O <= 1'b0;
			XSTROBE_OE_N_O <= 1'b1;
			XSTROBE_B_O <= 1'b1;
			XSTROBE_B_OE_N_O <= 1'b1;
		end else begin
			PULLUP_STEP_O <= pu_step;
			PULLDN_STEP_O <= pd_step;
			strobe_phase <= reading ? !strobe_phase : 1'b0;
			if (drive_on) begin
				DQ_O <= drive_level;
				DQS_O <= drive_level;
				DQS_B_O <= !drive_level;
				XSTROBE_O <= drive_level;
				XSTROBE_B_O <= !drive_level;
				DQ_OE_N_O <= outputs_off;
				DQS_OE_N_O <= outputs_off;
				DQS_B_OE_N_O <= outputs_off || ext_one[`F_SE_STROBE];
				XSTROBE_OE_N_O <= outputs_off || !x8_strobe;
				XSTROBE_B_OE_N_O <= outputs_off || !(x8_strobe && !ext_one[`F_SE_STROBE]);
			end else begin
				DQ_O <= 1'b0;
				DQS_O <= strobe_phase;
				DQS_B_O <= !strobe_phase;
				XSTROBE_O <= strobe_phase;
				XSTROBE_B_O <= !strobe_phase;
				DQ_OE_N_O <= !(reading && !outputs_off);
				DQS_OE_N_O <= !(reading && !outputs_off);
				DQS_B_OE_N_O <= !(reading && !outputs_off && !ext_one[`F_SE_STROBE]);
				XSTROBE_OE_N_O <= !(reading && !outputs_off && x8_strobe);
				XSTROBE_B_OE_N_O <= !(reading && !outputs_off && x8_strobe
					&& !ext_one[`F_SE_STROBE]);
			end
		end
	end
endmodule
`default_nettype wire

// ### verification/ext_cfg_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// Pin relations that must hold whatever the controller sends.
module ext_cfg_monitor (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic DLL_EN_O,
	input wire logic DLL_RESET_O,
	input wire logic [3:0] PULLUP_STEP_O,
	input wire logic [3:0] PULLDN_STEP_O,
	input wire logic DQ_OE_N_O,
	input wire logic DQS_O,
	input wire logic DQS_OE_N_O,
	input wire logic DQS_B_O,
	input wire logic DQS_B_OE_N_O,
	input wire logic XSTROBE_O,
	input wire logic XSTROBE_OE_N_O,
	input wire logic XSTROBE_B_O,
	input wire logic XSTROBE_B_OE_N_O,
	input wire logic DATA_MASK_EN_O
);
	default clocking mon_cb @(posedge CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	// A complement strobe never stands alone; it always mirrors its true strobe.
	dqsb_needs_a: assert property (!DQS_B_OE_N_O |-> !DQS_OE_N_O)
		else $error("complement strobe driven alone");
	dqsb_inverse_a: assert property (!DQS_B_OE_N_O |-> DQS_B_O != DQS_O)
		else $error("complement strobe not inverted");
	xstb_needs_a: assert property (!XSTROBE_B_OE_N_O |->
		!XSTROBE_OE_N_O && !DQS_B_OE_N_O)
		else $error("extra complement strobe driven wrongly");
	xstb_inverse_a: assert property (!XSTROBE_B_OE_N_O |-> XSTROBE_B_O != XSTROBE_O)
		else $error("extra complement strobe not inverted");
	mask_off_a: assert property (!XSTROBE_OE_N_O |-> !DATA_MASK_EN_O)
		else $error("mask still on while extra strobe drives");
	// The loop reset is a single pulse and the loop is running soon after.
	dll_pulse_a: assert property (DLL_RESET_O |=> !DLL_RESET_O)
		else $error("loop reset longer than one cycle");
	dll_back_a: assert property (DLL_RESET_O |-> ##[0:2] DLL_EN_O)
		else $error("loop not enabled after reset");
	// Steps move only in the adjust beats or on a default load, never while data drivers are on.
	steps_hold_a: assert property (!DQ_OE_N_O |->
		$stable(PULLUP_STEP_O) && $stable(PULLDN_STEP_O))
		else $error("impedance moved while driving");
	dq_with_dqs_a: assert property (!DQ_OE_N_O |-> !DQS_OE_N_O)
		else $error("data driven without strobe");
endmodule
`default_nettype wire

// ### verification/ext_cfg_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "ext_cfg_consts.vh"
// Controller side: an APB master that also forms mode-set commands.
module ext_cfg_ctrl_model (
	input wire logic clk_i,
	input wire logic pready_i,
	input wire logic [31:0] prdata_i,
	output var logic psel_o,
	output var logic penable_o,
	output var logic pwrite_o,
	output var logic [11:0] paddr_o,
	output var logic [31:0] pwdata_o
);
	// Idle bus until the first request.
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 12'h000;
		pwdata_o = 32'h00000000;
	end
	// Released lines show inverted values so stale data cannot pass as valid.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		psel_o <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		@(posedge clk_i);
		while (pready_i !== 1'b1) @(posedge clk_i);
		q = prdata_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		paddr_o <= ~a;
		pwdata_o <= ~d;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		xfer(1'b0, a, 32'h00000000, q);
	endtask
	task automatic cfg(input logic [2:0] ba, input logic [15:0] a);
		wr(`REG_CMD_ADDR, {19'h00000, a[12:0]});
		wr(`REG_CMD_CTRL, {20'h00000, 4'h8, 1'b1, ba, 4'h0});
	endtask
endmodule
`default_nettype wire

// ### verification/test_ext_cfg_block.sv
`timescale 1ns/100ps
`default_nettype none
`include "ext_cfg_consts.vh"
module test_ext_cfg_block;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, rst_seen;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic dll_en, dll_rst, half, dq, dq_oe_n, dqs, dqs_oe_n, dqsb, dqsb_oe_n;
	logic xs, xs_oe_n, xsb, xsb_oe_n, dm_en;
	logic [1:0] term;
	logic [2:0] al;
	logic [3:0] pu, pd;
	int fails, checked;
	// Enables and masked pin levels, so undriven pins never count.
	wire [5:0] oes = {dq_oe_n, dqs_oe_n, dqsb_oe_n, xs_oe_n, xsb_oe_n, dm_en};
	wire [4:0] pins = {dq, dqs, dqsb, xs, xsb} & ~oes[5:1];
	ext_cfg_block ext_cfg_block_i (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .DLL_EN_O(dll_en),
		.DLL_RESET_O(dll_rst), .HALF_DRIVE_O(half), .TERM_SEL_O(term),
		.ADDED_LATENCY_O(al), .PULLUP_STEP_O(pu), .PULLDN_STEP_O(pd), .DQ_O(dq),
		.DQ_OE_N_O(dq_oe_n), .DQS_O(dqs), .DQS_OE_N_O(dqs_oe_n), .DQS_B_O(dqsb),
		.DQS_B_OE_N_O(dqsb_oe_n), .XSTROBE_O(xs), .XSTROBE_OE_N_O(xs_oe_n),
		.XSTROBE_B_O(xsb), .XSTROBE_B_OE_N_O(xsb_oe_n), .DATA_MASK_EN_O(dm_en));
	ext_cfg_ctrl_model ext_cfg_ctrl_model_i (.clk_i(clk), .pready_i(pready),
		.prdata_i(prdata), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
		.paddr_o(paddr), .pwdata_o(pwdata));
	// Free-running clock at 200 MHz.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Remember any loop reset pulse for the self-refresh check.
	always @(posedge clk) begin
		if (dll_rst === 1'b1)
			rst_seen <= 1'b1;
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic finish_test();
		if (fails == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		ext_cfg_ctrl_model_i.wr(a, d);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		ext_cfg_ctrl_model_i.rd(a, q);
	endtask
	// Mode-set command, then time for fields and drivers to settle.
	task automatic cmd(input logic [2:0] ba, input logic [15:0] a);
		ext_cfg_ctrl_model_i.cfg(ba, a);
		repeat (10) @(posedge clk);
	endtask
	task automatic t_reset();
		logic [31:0] q;
		rd(`REG_CMD_CTRL, q);
		chk("ctrl reset", q, 32'h0000000F);
		rd(12'h0FC, q);
		chk("unmapped read", q, 32'h00000000);
		chk("reset steps", {pd, pu}, 32'h00000088);
		chk("reset drivers", oes, 32'h0000003F);
		chk("bus status", {pready, pslverr}, 32'h00000002);
	endtask
	task automatic t_fields();
		logic [31:0] q;
		cmd(3'h2, 16'h0005);
		rd(`REG_EXT_TWO, q);
		chk("ext two", q, 32'h00000005);
		cmd(3'h3, 16'h0000);
		rd(`REG_EXT_THREE, q);
		chk("ext three", q, 32'h00000000);
		cmd(3'h1, 16'h001E);
		chk("fields", {dll_en, half, term, al}, 32'h0000006B);
		cmd(3'h1, 16'h0041);
		rd(`REG_EXT_ONE, q);
		chk("ext one", q, 32'h00000041);
		chk("fields two", {dll_en, half, term, al}, 32'h00000010);
		cmd(3'h0, 16'h0002);
		chk("base ignored", half, 32'h00000000);
		wr(`REG_CMD_CTRL, 32'h00000891);
		repeat (10) @(posedge clk);
		chk("deselect ignored", half, 32'h00000000);
	endtask
	task automatic t_drive();
		logic [26:0] tbl [5] = '{{16'h0080, 6'h07, 5'h18}, {16'h0100, 6'h07, 5'h04},
			{16'h0880, 6'h00, 5'h1A}, {16'h0D00, 6'h0A, 5'h00}, {16'h1080, 6'h3F, 5'h00}};
		for (int i = 0; i < 5; i++) begin
			cmd(3'h1, tbl[i][26:11]);
			chk("drive enables", oes, tbl[i][10:5]);
			chk("drive levels", pins, tbl[i][4:0]);
			cmd(3'h1, 16'h0000);
			chk("exit enables", oes, 32'h0000003F);
		end
	endtask
	task automatic adj(input logic [3:0] code);
		wr(`REG_CMD_ADDR, {28'h0000000, code});
		wr(`REG_CMD_CTRL, 32'h00000C82);
		repeat (8) @(posedge clk);
	endtask
	// Bit n of the staged word is beat n; beat zero is the code's first bit.
	task automatic t_cal();
		logic [31:0] q;
		cmd(3'h1, 16'h0218);
		repeat (8) adj(4'hA);
		chk("steps saturate", {pd, pu}, 32'h000000FF);
		adj(4'h4);
		chk("pull-up down", {pd, pu}, 32'h000000FE);
		rd(`REG_CAL_CODE, q);
		chk("code beats", q, 32'h00000002);
		adj(4'h1);
		chk("pull-down down", {pd, pu}, 32'h000000EE);
		adj(4'hF);
		chk("reserved code", {pd, pu}, 32'h000000EE);
		rd(`REG_IMPEDANCE, q);
		chk("step readback", q, 32'h000000EE);
		chk("latency kept", al, 32'h00000003);
		cmd(3'h1, 16'h0018);
		cmd(3'h1, 16'h0380);
		cmd(3'h1, 16'h0000);
		chk("default steps", {pd, pu}, 32'h00000088);
	endtask
	task automatic t_read(input logic [15:0] a, input logic [1:0] exp);
		logic [1:0] seen;
		seen = 2'b00;
		cmd(3'h1, a);
		wr(`REG_CMD_CTRL, 32'h00000A8A);
		repeat (16) begin
			@(posedge clk);
			seen = seen | ~{dq_oe_n, xs_oe_n};
		end
		chk("read drive", seen, exp);
	endtask
	task automatic t_sref();
		logic [31:0] q;
		wr(`REG_CMD_CTRL, 32'h0000098F);
		repeat (6) @(posedge clk);
		chk("loop asleep", dll_en, 32'h00000000);
		rst_seen <= 1'b0;
		wr(`REG_CMD_CTRL, 32'h0000088F);
		repeat (6) @(posedge clk);
		chk("loop back", {dll_en, rst_seen}, 32'h00000003);
		repeat (200) @(posedge clk);
		rd(`REG_STATUS, q);
		chk("lock count", q, 32'h00000C81);
		t_read(16'h1800, 2'b00);
		t_read(16'h0800, 2'b11);
	endtask
	// Main sequence.
	initial begin
		fails = 0;
		checked = 0;
		rst_seen = 1'b0;
		rst_n = 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_fields();
		t_drive();
		t_cal();
		t_sref();
		finish_test();
	end
	// Watchdog well beyond the expected run of under a thousand cycles.
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		finish_test();
	end
endmodule
bind ext_cfg_block ext_cfg_monitor ext_cfg_monitor_i (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
	.DLL_EN_O(DLL_EN_O), .DLL_RESET_O(DLL_RESET_O), .PULLUP_STEP_O(PULLUP_STEP_O),
	.PULLDN_STEP_O(PULLDN_STEP_O), .DQ_OE_N_O(DQ_OE_N_O), .DQS_O(DQS_O),
	.DQS_OE_N_O(DQS_OE_N_O), .DQS_B_O(DQS_B_O), .DQS_B_OE_N_O(DQS_B_OE_N_O),
	.XSTROBE_O(XSTROBE_O), .XSTROBE_OE_N_O(XSTROBE_OE_N_O), .XSTROBE_B_O(XSTROBE_B_O),
	.XSTROBE_B_OE_N_O(XSTROBE_B_OE_N_O), .DATA_MASK_EN_O(DATA_MASK_EN_O));
`default_nettype wire
